//--- rtl/ext_reset_filter.sv
// Pulse width qualifier for the external reset pin
`include "rst_pwr_params.svh"

module ext_reset_filter #(
   parameter int MIN_CYC = `RPG_EXT_MIN_CYC
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Pin
   input wire logic pin_n_i,
   // Qualified request
   output logic req_o
);
   logic [7:0] low_cnt_reg;

   // ==========================================
   // Low level counter
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         low_cnt_reg <= 8'h00;
      end
      else if (pin_n_i)
      begin
         low_cnt_reg <= 8'h00;
      end
      else if (low_cnt_reg < 8'(MIN_CYC))
      begin
         low_cnt_reg <= low_cnt_reg + 8'h01;
      end
   end

   // Shorter pulses are filtered out
   assign req_o = !pin_n_i && (low_cnt_reg >= 8'(MIN_CYC));
endmodule

//--- rtl/reset_and_sleep_power_gating.sv
// Reset source combiner, reset stretch and sleep-time power gating
// ==========================================
// Overview of operation
// - Enabled converter stays powered in sleep
// - First conversion after re-enable is extended
// - Comparator off in deep sleep modes
// - Reference kept on for comparator bandgap
// - Reference on when any user needs
// - Brown-out detector runs in all sleep
// - Enabled watchdog keeps running in sleep
// - Input buffers except wake pins off when I/O, ADC clocks stop
// - Disable-register bits turn input buffers off
// - Debug fuse keeps main clock in sleep while scan port enabled
// - Scan port off by bit or fuse
// - Test data out undriven when not shifting
// - Reset loads I/O; restart at vector
// - Port reset asynchronous on any source but the clocked pin filter
// - Stretch counter starts after sources clear
// - Stretch length from startup, clock fuses
// - Long low reset pin causes reset
// - Watchdog expiry resets when enabled
// - Enabled brown-out below threshold resets
// - Held while debugger reset register one
// - Power-on drop resets with no delay
// - Mode 010 is power-down, clocks halted
// - Reset cause flags readable by software
`include "rst_pwr_params.svh"

module reset_and_sleep_power_gating #(
   parameter int DIS_W = 8
)
(
   // Clock and power-on reset from the supply detector
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Reset sources
   input wire logic ext_reset_n_i,
   input wire logic wdt_expire_i,
   input wire logic wdt_enable_i,
   input wire logic bod_below_i,
   input wire logic scan_reset_bit_i,
   // Fuses
   input wire logic [2:0] brownout_level_fuses_i,
   input wire logic [1:0] startup_time_fuses_i,
   input wire logic [3:0] clock_select_fuses_i,
   input wire logic onchip_debug_fuse_i,
   input wire logic scan_port_enable_fuse_i,
   // Software control
   input wire logic scan_port_disable_bit_i,
   input wire logic sleep_i,
   input wire logic [2:0] sleep_mode_select_i,
   input wire logic adc_enable_i,
   input wire logic acmp_enable_i,
   input wire logic acmp_bandgap_i,
   input wire logic [DIS_W-1:0] input_disable_reg_lo_i,
   input wire logic [DIS_W-1:0] input_disable_reg_hi_i,
   input wire logic [DIS_W-1:0] wake_pin_lo_i,
   input wire logic [DIS_W-1:0] wake_pin_hi_i,
   input wire logic cause_clear_i,
   input wire logic [`RPG_CAUSE_W-1:0] cause_clear_mask_i,
   input wire logic adc_ext_conv_done_i,
   // Scan port
   input wire logic tap_shifting_i,
   input wire logic tdo_data_i,
   // Reset outputs
   output logic port_reset_o,
   output logic core_reset_o,
   output logic fetch_vector_o,
   // Reset cause
   output logic [`RPG_CAUSE_W-1:0] reset_cause_register_o,
   // Power gating
   output logic adc_power_o,
   output logic adc_extended_conv_o,
   output logic acmp_power_o,
   output logic vref_enable_o,
   output logic bod_enable_o,
   output logic wdt_run_o,
   output logic main_clk_run_o,
   output logic clk_io_run_o,
   output logic clk_adc_run_o,
   output logic [DIS_W-1:0] inbuf_en_lo_o,
   output logic [DIS_W-1:0] inbuf_en_hi_o,
   // Scan port
   output logic scan_port_en_o,
   output logic tdo_o,
   output logic tdo_oe_o
);
   logic ext_req;
   logic bod_on;
   logic bod_req;
   logic wdt_req;
   logic any_req;
   logic stretch;
   logic deep_sleep;
   logic [1:0] clk_run;
   logic adc_en_d_reg;
   logic ext_conv_reg;
   logic [`RPG_CAUSE_W-1:0] cause_reg;
   logic [`RPG_CAUSE_W-1:0] cause_set;
   logic por_seen_reg;
   rst_pwr_pkg::tout_t tout_len;
   rst_pwr_pkg::rst_state_e state_reg;
   rst_pwr_pkg::rst_state_e state_next;

   // Clock domain activity by mode; unknown modes treated as power-down
   function automatic logic [1:0] clk_io_adc(input logic [2:0] mode);
      case (mode)
         `RPG_SM_IDLE: clk_io_adc = 2'h3;
         `RPG_SM_ADC_NR: clk_io_adc = 2'h1;
         `RPG_SM_PWR_DOWN: clk_io_adc = 2'h0;
         default: clk_io_adc = 2'h0;
      endcase
   endfunction

   // ==========================================
   // Reset sources
   ext_reset_filter u_ext_filter
   (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .pin_n_i(ext_reset_n_i),
      .req_o(ext_req)
   );

   assign bod_on = (brownout_level_fuses_i != `RPG_BOD_OFF);
   assign bod_req = bod_on && bod_below_i;
   assign wdt_req = wdt_enable_i && wdt_expire_i;
   // Debugger sets and clears the register; reset held throughout
   assign any_req = ext_req || bod_req || wdt_req || scan_reset_bit_i;

   // Port reset is purely combinational so every source but the clocked pin filter acts with no clock running
   assign port_reset_o = !rst_n_i || any_req;

   // ==========================================
   // Stretch length from fuses
   always_comb
   begin
      case (startup_time_fuses_i)
         2'h0: tout_len = `RPG_TOUT_NONE;
         2'h1: tout_len = `RPG_TOUT_SHORT;
         2'h2: tout_len = `RPG_TOUT_MED;
         default: tout_len = `RPG_TOUT_LONG;
      endcase
      // External clock selection needs no oscillator settle time
      if (clock_select_fuses_i == 4'h0 && startup_time_fuses_i != 2'h0)
      begin
         tout_len = `RPG_TOUT_SHORT;
      end
   end

   stretch_counter u_stretch
   (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .req_i(any_req),
      .len_i(tout_len),
      .stretch_o(stretch)
   );

   // ==========================================
   // Reset sequencing state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         rst_pwr_pkg::RST_ACTIVE:
         begin
            if (!any_req)
            begin
               state_next = rst_pwr_pkg::RST_STRETCH;
            end
         end
         rst_pwr_pkg::RST_STRETCH:
         begin
            if (any_req)
            begin
               state_next = rst_pwr_pkg::RST_ACTIVE;
            end
            else if (!stretch)
            begin
               state_next = rst_pwr_pkg::RST_RUN;
            end
         end
         rst_pwr_pkg::RST_RUN:
         begin
            if (any_req)
            begin
               state_next = rst_pwr_pkg::RST_ACTIVE;
            end
         end
         default: state_next = rst_pwr_pkg::RST_ACTIVE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= rst_pwr_pkg::RST_ACTIVE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // I/O registers reload while this is high
   assign core_reset_o = !rst_n_i || (state_reg != rst_pwr_pkg::RST_RUN);

   // One-cycle pulse: execution starts from the reset vector
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fetch_vector_o <= 1'b0;
      end
      else
      begin
         fetch_vector_o <= (state_reg == rst_pwr_pkg::RST_STRETCH) &&
                           (state_next == rst_pwr_pkg::RST_RUN);
      end
   end

   // ==========================================
   // Reset cause flags; set wins over a simultaneous clear
   always_comb
   begin
      cause_set = '0;
      cause_set[`RPG_CAUSE_EXT] = ext_req;
      cause_set[`RPG_CAUSE_BOD] = bod_req;
      cause_set[`RPG_CAUSE_WDT] = wdt_req;
      cause_set[`RPG_CAUSE_JTAG] = scan_reset_bit_i;
   end

   // Power-on flag is caught on the first clock after power-on release
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         por_seen_reg <= 1'b0;
      end
      else
      begin
         por_seen_reg <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cause_reg <= '0;
      end
      else
      begin
         if (cause_clear_i)
         begin
            cause_reg <= (cause_reg & ~cause_clear_mask_i) | cause_set;
         end
         else
         begin
            cause_reg <= cause_reg | cause_set;
         end
         if (!por_seen_reg)
         begin
            cause_reg[`RPG_CAUSE_POR] <= 1'b1;
         end
      end
   end

   assign reset_cause_register_o = cause_reg;

   // ==========================================
   // Sleep clock and power gating
   assign deep_sleep = sleep_i && (sleep_mode_select_i != `RPG_SM_IDLE) &&
                       (sleep_mode_select_i != `RPG_SM_ADC_NR);
   assign clk_run = clk_io_adc(sleep_mode_select_i);
   assign clk_io_run_o = !sleep_i || clk_run[1];
   assign clk_adc_run_o = !sleep_i || clk_run[0];

   // Sleep never removes power from an enabled converter
   assign adc_power_o = adc_enable_i;
   assign acmp_power_o = acmp_enable_i && !deep_sleep;
   // A bandgap-fed comparator keeps the reference on in any mode
   assign vref_enable_o = bod_on || (acmp_enable_i && acmp_bandgap_i) ||
                          adc_enable_i;
   assign bod_enable_o = bod_on;
   assign wdt_run_o = wdt_enable_i;
   // Debug only holds the clock while the scan port is usable
   assign main_clk_run_o = !sleep_i || (onchip_debug_fuse_i && scan_port_en_o) ||
                           (sleep_mode_select_i == `RPG_SM_IDLE) ||
                           (sleep_mode_select_i == `RPG_SM_ADC_NR) ||
                           (sleep_mode_select_i == `RPG_SM_STANDBY);

   // Wake pins not set in the disable register keep their buffer even when both clocks stop
   assign inbuf_en_lo_o = ~input_disable_reg_lo_i &
                          ((clk_io_run_o || clk_adc_run_o) ? '1 : wake_pin_lo_i);
   assign inbuf_en_hi_o = ~input_disable_reg_hi_i &
                          ((clk_io_run_o || clk_adc_run_o) ? '1 : wake_pin_hi_i);

   // ==========================================
   // Extended conversion after the converter was off
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         adc_en_d_reg <= 1'b0;
      end
      else
      begin
         adc_en_d_reg <= adc_enable_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_conv_reg <= 1'b1;
      end
      else if (adc_enable_i && !adc_en_d_reg)
      begin
         ext_conv_reg <= 1'b1;
      end
      else if (adc_ext_conv_done_i)
      begin
         ext_conv_reg <= 1'b0;
      end
   end

   assign adc_extended_conv_o = ext_conv_reg;

   // ==========================================
   // Scan port enable and test data out
   assign scan_port_en_o = scan_port_enable_fuse_i && !scan_port_disable_bit_i;

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tdo_o <= 1'b0;
      end
      else
      begin
         tdo_o <= tdo_data_i;
      end
   end

   // Released while idle: board pull-up holds the line
   assign tdo_oe_o = scan_port_en_o && tap_shifting_i;
endmodule

//--- rtl/rst_pwr_params.svh
// Clock rate, encodings, field positions and timing counts for reset and sleep gating
`ifndef RST_PWR_PARAMS_SVH
`define RST_PWR_PARAMS_SVH

// Clock rate and reset pin minimum pulse
`define RPG_CLK_MHZ 25
`define RPG_EXT_MIN_PULSE_NS 400
// Least time rounds up
`define RPG_EXT_MIN_CYC ((`RPG_EXT_MIN_PULSE_NS * `RPG_CLK_MHZ + 999) / 1000)

// Sleep mode select encodings
`define RPG_SM_IDLE 3'h0
`define RPG_SM_ADC_NR 3'h1
`define RPG_SM_PWR_DOWN 3'h2
`define RPG_SM_PWR_SAVE 3'h3
`define RPG_SM_STANDBY 3'h6

// Brown-out level fuse code that turns the detector off
`define RPG_BOD_OFF 3'h7

// Reset cause flag positions
`define RPG_CAUSE_POR 0
`define RPG_CAUSE_EXT 1
`define RPG_CAUSE_BOD 2
`define RPG_CAUSE_WDT 3
`define RPG_CAUSE_JTAG 4
`define RPG_CAUSE_W 5

// Stretch counts in cycles, indexed by startup and clock select fuses
`define RPG_TOUT_SHORT 16'h0010
`define RPG_TOUT_MED 16'h0400
`define RPG_TOUT_LONG 16'h1000
`define RPG_TOUT_NONE 16'h0001

`endif

//--- rtl/rst_pwr_pkg.sv
// Types shared by the reset and sleep gating block
package rst_pwr_pkg;
   typedef enum logic [1:0]
   {
      RST_ACTIVE,
      RST_STRETCH,
      RST_RUN
   } rst_state_e;

   typedef logic [15:0] tout_t;
endpackage

//--- rtl/stretch_counter.sv
// Reset stretch delay counter
`include "rst_pwr_params.svh"

module stretch_counter
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic req_i,
   input wire rst_pwr_pkg::tout_t len_i,
   // Status
   output logic stretch_o
);
   rst_pwr_pkg::tout_t cnt_reg;

   // ==========================================
   // Counter restarts on every request, runs only once all sources clear
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_reg <= 16'h0000;
      end
      else if (req_i)
      begin
         cnt_reg <= len_i;
      end
      else if (cnt_reg != 16'h0000)
      begin
         cnt_reg <= cnt_reg - 16'h0001;
      end
   end

   assign stretch_o = (cnt_reg != 16'h0000);
endmodule

//--- tb/far_side_model.sv
// Far-side model: reset pin, supply monitor, debugger reset register, scan data pull-up
module far_side_model
(
   // Clock
   input wire logic sys_clk_i,
   // Reset sources
   output logic ext_reset_n_o,
   output logic bod_below_o,
   output logic scan_reset_bit_o,
   // Scan data pin
   input wire logic tdo_i,
   input wire logic tdo_oe_i,
   output wire logic tdo_wire_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Board pull-up holds the line high once the block lets go
   assign tdo_wire_o = tdo_oe_i ? tdo_i : 1'b1;

   initial
   begin
      ext_reset_n_o = 1'b1;
      bod_below_o = 1'b0;
      scan_reset_bit_o = 1'b0;
   end

   // One source active for n edges, released just after the last one
   task automatic hold(input int which, input int n);
      case (which)
         1: bod_below_o = 1'b1;
         2: ext_reset_n_o = 1'b0;
         default: scan_reset_bit_o = 1'b1;
      endcase
      repeat (n) @(posedge sys_clk_i);
      #1;
      ext_reset_n_o = 1'b1;
      bod_below_o = 1'b0;
      scan_reset_bit_o = 1'b0;
   endtask
endmodule

//--- tb/rst_pwr_sva.sv
// Port-level assertions for the reset and sleep power gating block
`include "rst_pwr_params.svh"

module rst_pwr_sva #(
   parameter int DIS_W = 8
)
(
   // Clock, reset, sources and controls
   input wire logic sys_clk_i, rst_n_i, wdt_expire_i, wdt_enable_i, bod_below_i,
   input wire logic scan_reset_bit_i, onchip_debug_fuse_i, sleep_i, tap_shifting_i,
   input wire logic adc_enable_i, acmp_enable_i, acmp_bandgap_i,
   input wire logic [2:0] brownout_level_fuses_i, sleep_mode_select_i,
   input wire logic [DIS_W-1:0] input_disable_reg_lo_i, wake_pin_lo_i,
   // Watched outputs
   input wire logic port_reset_o, core_reset_o, fetch_vector_o, adc_power_o, acmp_power_o,
   input wire logic vref_enable_o, main_clk_run_o, clk_io_run_o, clk_adc_run_o,
   input wire logic scan_port_en_o, tdo_oe_o,
   input wire logic [DIS_W-1:0] inbuf_en_lo_o,
   input wire logic [`RPG_CAUSE_W-1:0] reset_cause_register_o
);
   // ==========================================
   // Clocking and shared sequences
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   logic bod_on;
   assign bod_on = brownout_level_fuses_i != `RPG_BOD_OFF;

   sequence src_active;
      (wdt_expire_i && wdt_enable_i) || (bod_below_i && bod_on) || scan_reset_bit_i;
   endsequence
   sequence exit_pulse;
      !core_reset_o ##1 !fetch_vector_o;
   endsequence

   // ==========================================
   // Reset sources
   AST_SRC_PORT: assert property (src_active |-> port_reset_o)
      else $error("Port reset missing");
   AST_CORE_FOLLOW: assert property (port_reset_o |=> core_reset_o)
      else $error("Core reset not held");
   AST_FETCH: assert property (fetch_vector_o |-> exit_pulse)
      else $error("Bad vector fetch pulse");
   AST_WDT_CAUSE: assert property (wdt_expire_i && wdt_enable_i
      |=> reset_cause_register_o[`RPG_CAUSE_WDT]) else $error("Watchdog flag missing");
   AST_BOD_CAUSE: assert property (bod_below_i && bod_on
      |=> reset_cause_register_o[`RPG_CAUSE_BOD]) else $error("Brown-out flag missing");

   // ==========================================
   // Sleep gating
   AST_ADC_ON: assert property (sleep_i && adc_enable_i |-> adc_power_o)
      else $error("Converter lost power");
   AST_ACMP_OFF: assert property (sleep_i && sleep_mode_select_i > `RPG_SM_ADC_NR
      |-> !acmp_power_o) else $error("Comparator on in deep sleep");
   AST_VREF_ON: assert property (bod_on || adc_enable_i ||
      (acmp_bandgap_i && acmp_enable_i) |-> vref_enable_o)
      else $error("Reference off while needed");
   AST_VREF_OFF: assert property (!bod_on && !adc_enable_i && !acmp_bandgap_i
      |-> !vref_enable_o) else $error("Reference on while unused");
   AST_INBUF_DIS: assert property ((inbuf_en_lo_o & input_disable_reg_lo_i) == '0)
      else $error("Disabled buffer enabled");
   AST_INBUF_SLEEP: assert property (sleep_i && !clk_io_run_o && !clk_adc_run_o
      |-> (inbuf_en_lo_o & ~wake_pin_lo_i) == '0) else $error("Buffer on in sleep");
   AST_DBG_CLK: assert property (sleep_i && onchip_debug_fuse_i && scan_port_en_o
      |-> main_clk_run_o) else $error("Main clock stopped under debug");
   AST_TDO_FLOAT: assert property (scan_port_en_o && !tap_shifting_i |-> !tdo_oe_o)
      else $error("Scan data driven while idle");
endmodule

//--- tb/tb.sv
// Self-checking bench for the reset and sleep power gating block
`include "rst_pwr_params.svh"

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk_i = '0, rst_n_i = '0, wdt_expire_i = '0, wdt_enable_i = '0;
   logic onchip_debug_fuse_i = '0, scan_port_enable_fuse_i = '0, scan_port_disable_bit_i = '0;
   logic sleep_i = '0, adc_enable_i = '0, acmp_enable_i = '0, acmp_bandgap_i = '0;
   logic cause_clear_i = '0, adc_ext_conv_done_i = '0, tap_shifting_i = '0, tdo_data_i = '0;
   logic [2:0] brownout_level_fuses_i = 3'h7, sleep_mode_select_i = 3'h0;
   logic [1:0] startup_time_fuses_i = 2'h1;
   logic [3:0] clock_select_fuses_i = 4'h1;
   logic [`RPG_CAUSE_W-1:0] cause_clear_mask_i = 5'h1f, reset_cause_register_o;
   logic [7:0] input_disable_reg_lo_i = '0, input_disable_reg_hi_i = '0;
   logic [7:0] wake_pin_lo_i = '0, wake_pin_hi_i = '0, inbuf_en_lo_o, inbuf_en_hi_o;
   logic ext_reset_n_i, bod_below_i, scan_reset_bit_i, deep;
   wire tdo_wire;
   logic port_reset_o, core_reset_o, fetch_vector_o, adc_power_o, adc_extended_conv_o;
   logic acmp_power_o, vref_enable_o, bod_enable_o, wdt_run_o, main_clk_run_o;
   logic clk_io_run_o, clk_adc_run_o, scan_port_en_o, tdo_o, tdo_oe_o;
   int fail_count = 0, checks = 0, cycles = 0, fetch_seen = 0;
   logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
   int lens [5] = '{1, 16, 1024, 4096, 16};
   int bit_of [4] = '{3, 2, 1, 4};

   reset_and_sleep_power_gating #(.DIS_W(8)) DUT (.sys_clk_i, .rst_n_i, .ext_reset_n_i,
      .wdt_expire_i, .wdt_enable_i, .bod_below_i, .scan_reset_bit_i, .brownout_level_fuses_i,
      .startup_time_fuses_i, .clock_select_fuses_i, .onchip_debug_fuse_i,
      .scan_port_enable_fuse_i, .scan_port_disable_bit_i, .sleep_i, .sleep_mode_select_i,
      .adc_enable_i, .acmp_enable_i, .acmp_bandgap_i, .input_disable_reg_lo_i,
      .input_disable_reg_hi_i, .wake_pin_lo_i, .wake_pin_hi_i, .cause_clear_i,
      .cause_clear_mask_i, .adc_ext_conv_done_i, .tap_shifting_i, .tdo_data_i, .port_reset_o,
      .core_reset_o, .fetch_vector_o, .reset_cause_register_o, .adc_power_o,
      .adc_extended_conv_o, .acmp_power_o, .vref_enable_o, .bod_enable_o, .wdt_run_o,
      .main_clk_run_o, .clk_io_run_o, .clk_adc_run_o, .inbuf_en_lo_o, .inbuf_en_hi_o,
      .scan_port_en_o, .tdo_o, .tdo_oe_o);

   far_side_model far (.sys_clk_i, .ext_reset_n_o(ext_reset_n_i), .bod_below_o(bod_below_i),
      .scan_reset_bit_o(scan_reset_bit_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
      .tdo_wire_o(tdo_wire));

   initial
   begin
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   // Sampled on the falling edge so registered outputs have settled
   always @(negedge sys_clk_i)
   begin
      cycles++;
      if (fetch_vector_o === 1'b1)
         fetch_seen++;
      if (cycles == 20000)
      begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (fail_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // Bounded wait for the internal reset to end; n is the cycles it took
   task automatic wait_run(output int n);
      n = 0;
      while (core_reset_o !== 1'b0 && n < 5000)
      begin
         step(1);
         n++;
      end
   endtask

   // Trigger one source, enabled or not, and look at the cause flags it leaves
   task automatic hit(input int src, input logic en);
      int n;
      cause_clear_i = 1'b1;
      wdt_enable_i = en;
      brownout_level_fuses_i = en ? 3'h0 : 3'h7;
      step(1);
      cause_clear_i = 1'b0;
      check("run_levels", {en, en}, {wdt_run_o, bod_enable_o});
      if (src == 0)
      begin
         wdt_expire_i = 1'b1;
         #1;
         check("wdt_port_reset", en, port_reset_o);
         step(1);
         wdt_expire_i = 1'b0;
      end
      else
         far.hold(src, (src == 2 && !en) ? 8 : 12);
      wait_run(n);
      check("cause", en ? 5'h01 << bit_of[src] : 5'h00, reset_cause_register_o);
   endtask

   initial
   begin
      int n;
      step(12);
      check("reset_values", 16'h0007, {reset_cause_register_o, fetch_vector_o, tdo_o,
         adc_extended_conv_o, port_reset_o, core_reset_o});
      rst_n_i = 1'b1;
      wait_run(n);
      step(2);
      check("por_cause", 5'h01, reset_cause_register_o);
      check("fetch_pulses", 16'h0001, 16'(fetch_seen));
      adc_enable_i = 1'b1;
      step(1);
      adc_ext_conv_done_i = 1'b1;
      step(1);
      adc_ext_conv_done_i = 1'b0;
      step(1);
      check("ext_conv_done", 1'b0, adc_extended_conv_o);
      adc_enable_i = 1'b0;
      step(2);
      adc_enable_i = 1'b1;
      step(2);
      check("ext_conv_again", 1'b1, adc_extended_conv_o);
      sleep_i = 1'b1;
      acmp_enable_i = 1'b1;
      input_disable_reg_lo_i = 8'h0f;
      input_disable_reg_hi_i = 8'h81;
      wake_pin_lo_i = 8'h30;
      wake_pin_hi_i = 8'h03;
      foreach (modes[i])
      begin
         sleep_mode_select_i = modes[i];
         step(1);
         deep = modes[i] > 3'h1;
         check("clk_io", modes[i] == 3'h0, clk_io_run_o);
         check("clk_adc", !deep, clk_adc_run_o);
         check("acmp_power", !deep, acmp_power_o);
         check("adc_power", 1'b1, adc_power_o);
         check("main_clk", !deep || modes[i] == 3'h6, main_clk_run_o);
         check("inbuf", deep ? 16'h0230 : 16'h7ef0, {inbuf_en_hi_o, inbuf_en_lo_o});
      end
      sleep_mode_select_i = 3'h2;
      onchip_debug_fuse_i = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         {scan_port_disable_bit_i, scan_port_enable_fuse_i} = 2'(k);
         step(1);
         check("scan_en", k == 1, scan_port_en_o);
         check("debug_clk", k == 1, main_clk_run_o);
      end
      scan_port_disable_bit_i = 1'b0;
      step(1);
      check("tdo_idle", 2'h1, {tdo_oe_o, tdo_wire});
      tap_shifting_i = 1'b1;
      step(2);
      check("tdo_shift", 2'h2, {tdo_oe_o, tdo_wire});
      tdo_data_i = 1'b1;
      step(1);
      check("tdo_drive", 2'h3, {tdo_oe_o, tdo_wire});
      tap_shifting_i = 1'b0;
      adc_enable_i = 1'b0;
      step(1);
      check("vref_off", 1'b0, vref_enable_o);
      acmp_bandgap_i = 1'b1;
      step(1);
      check("vref_acmp_sleep", 1'b1, vref_enable_o);
      acmp_bandgap_i = 1'b0;
      brownout_level_fuses_i = 3'h0;
      step(1);
      check("vref_bod", 1'b1, vref_enable_o);
      sleep_i = 1'b0;
      for (int s = 0; s < 4; s++)
         for (int e = (s == 3); e < 2; e++)
            hit(s, e[0]);
      for (int t = 0; t < 5; t++)
      begin
         startup_time_fuses_i = (t == 4) ? 2'h2 : 2'(t);
         clock_select_fuses_i = (t == 4) ? 4'h0 : 4'h1;
         step(1);
         far.hold(3, 3);
         wait_run(n);
         check("stretch", 1'b1, n >= lens[t] && n <= lens[t] + 3);
      end
      rst_n_i = 1'b0;
      #1;
      check("async_reset", 2'h3, {port_reset_o, core_reset_o});
      step(2);
      rst_n_i = 1'b1;
      wait_run(n);
      step(1);
      check("por_again", 5'h01, reset_cause_register_o);
      cause_clear_mask_i = 5'h1e;
      cause_clear_i = 1'b1;
      step(1);
      check("cause_keep", 5'h01, reset_cause_register_o);
      print_verdict();
   end
endmodule

bind reset_and_sleep_power_gating rst_pwr_sva #(.DIS_W(DIS_W)) chk (.sys_clk_i, .rst_n_i,
   .wdt_expire_i, .wdt_enable_i, .bod_below_i, .scan_reset_bit_i, .onchip_debug_fuse_i,
   .sleep_i, .tap_shifting_i, .adc_enable_i, .acmp_enable_i, .acmp_bandgap_i,
   .brownout_level_fuses_i, .sleep_mode_select_i, .input_disable_reg_lo_i, .wake_pin_lo_i,
   .port_reset_o, .core_reset_o, .fetch_vector_o, .adc_power_o, .acmp_power_o, .vref_enable_o,
   .main_clk_run_o, .clk_io_run_o, .clk_adc_run_o, .scan_port_en_o, .tdo_oe_o, .inbuf_en_lo_o,
   .reset_cause_register_o);
